// file: common/pio_pkg.sv
// Purpose: Shared constants and types of the parallel port block.
// Assumes: Register indices are word indices; byte address = index * 4.
// Notes:   Port numbering A=0 through H=7 throughout.
package pio_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          NPORT  = 8;
  localparam int          ADDR_W = 10;
  localparam logic [2:0]  PORT_A = 3'h0;
  localparam logic [2:0]  PORT_B = 3'h1;
  localparam logic [2:0]  PORT_C = 3'h2;
  localparam logic [2:0]  PORT_D = 3'h3;
  localparam logic [2:0]  PORT_E = 3'h4;
  localparam logic [2:0]  PORT_F = 3'h5;
  localparam logic [2:0]  PORT_G = 3'h6;
  localparam logic [2:0]  PORT_H = 3'h7;

  // ----------------------------------------------------------------
  // Register indices, listed port H down to port A
  // ----------------------------------------------------------------
  localparam logic [7:0][7:0] DATA_IDX = {8'h7C, 8'h7E, 8'h05, 8'h0A,
                                          8'h08, 8'h03, 8'h04, 8'h00};
  localparam logic [7:0][7:0] DIR_IDX  = {8'h7D, 8'h7F, 8'h0B, 8'h00,
                                          8'h09, 8'h07, 8'h06, 8'h01};
  localparam logic [7:0]      HAS_DIR  = 8'hEF;
  localparam logic [7:0][7:0] PIN_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                          8'h3F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0]      SYSOPT_IDX = 8'h38;
  localparam logic [7:0]      PULL_IDX = 8'h2C;
  localparam logic [7:0]      CSC_IDX  = 8'h2D;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         OD_BIT    = 5;
  localparam int         IRV_BIT   = 4;
  localparam int         PGATE_BIT = 7;
  localparam int         XA_BIT    = 4;
  localparam logic [3:0] CS_RESET  = 4'h8;
  localparam int         MODE_EXP  = 1;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [7:0][7:0] pio_bank_t;

  typedef struct packed {
    logic       hit;
    logic       data;
    logic       dir;
    logic       sysopt;
    logic       pull;
    logic       csc;
    logic [2:0] port;
  } pio_dec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [5:0]  xaddr;
    logic [7:0]  wdata;
    logic        write;
    logic        rvis;
    logic [7:0]  rvis_data;
  } pio_ext_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] oe;
    logic [7:0] out;
  } pio_func_t;

  typedef struct packed {
    pio_bank_t   sync1;
    pio_bank_t   sync2;
    pio_bank_t   latch;
    pio_bank_t   dir;
    pio_bank_t   pout;
    pio_bank_t   poe;
    logic [1:0]  mode_s1;
    logic [1:0]  mode_s2;
    logic [1:0]  mode;
    logic [1:0]  strap_age;
    logic        mode_ok;
    logic        od;
    logic        irv;
    logic        irv_done;
    logic        pull_gate;
    logic [3:0]  pull;
    logic [3:0]  pull_en;
    logic [3:0]  cs_en;
    logic        xa_en;
    logic        e_tog;
    logic        e_clk;
    logic [7:0]  ext_rdata;
    logic [7:0]  an_data;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pio_state_t;

  localparam pio_state_t ST_RESET = '{cs_en: CS_RESET, default: '0};

endpackage : pio_pkg

// file: rtl/pio_parallel_ports.sv
// Purpose: Eight-port parallel I/O with APB register access.
// Assumes: Pin inputs and mode straps are asynchronous to pclk;
//          function units and bus interface run on pclk.
// Notes:   Pins are split into input, output and output enable.
`timescale 1ns/1ps

module pio_parallel_ports (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pio_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [1:0]                  mode_pins,
  input  wire pio_pkg::pio_bank_t          pin_in,
  output pio_pkg::pio_bank_t               pin_out,
  output pio_pkg::pio_bank_t               pin_oe,
  input  wire pio_pkg::pio_func_t          timer_func,
  input  wire pio_pkg::pio_func_t          serial_func,
  input  wire logic                        analog_en,
  output logic      [7:0]                  analog_data,
  input  wire logic [3:0]                  pwm_en,
  input  wire logic [3:0]                  pwm_out,
  input  wire logic [3:0]                  cs_sel,
  input  wire pio_pkg::pio_ext_t           ext,
  output logic      [7:0]                  ext_rdata,
  output logic                             e_clk,
  output logic      [3:0]                  pullup_en
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic pio_pkg::pio_dec_t pio_decode(
    input logic [pio_pkg::ADDR_W-1:0] a
  );
    pio_pkg::pio_dec_t d;
    logic [7:0]        idx;
    d   = '0;
    idx = a[pio_pkg::ADDR_W-1:2];
    if (a[1:0] == 2'h0) begin
      for (int p = 0; p < pio_pkg::NPORT; p++) begin
        if (idx == pio_pkg::DATA_IDX[p]) begin
          d.hit  = 1'b1;
          d.data = 1'b1;
          d.port = 3'(p);
        end
        if (pio_pkg::HAS_DIR[p] && idx == pio_pkg::DIR_IDX[p]) begin
          d.hit  = 1'b1;
          d.dir  = 1'b1;
          d.port = 3'(p);
        end
      end
      d.sysopt = (idx == pio_pkg::SYSOPT_IDX);
      d.pull   = (idx == pio_pkg::PULL_IDX);
      d.csc    = (idx == pio_pkg::CSC_IDX);
      d.hit    = d.hit | d.sysopt | d.pull | d.csc;
    end
    return d;
  endfunction : pio_decode

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pio_pkg::pio_state_t st;
  pio_pkg::pio_state_t next_st;
  pio_pkg::pio_dec_t   dec;
  pio_pkg::pio_bank_t  sp_en;
  pio_pkg::pio_bank_t  sp_oe;
  pio_pkg::pio_bank_t  sp_out;
  pio_pkg::pio_bank_t  rd_pins;
  logic                exp_mode;
  logic                sgl_mode;
  logic                wr;
  logic                setup;
  logic [7:0]          rd;

  assign dec      = pio_decode(paddr);
  assign exp_mode = st.mode_ok & st.mode[pio_pkg::MODE_EXP];
  assign sgl_mode = st.mode_ok & ~st.mode[pio_pkg::MODE_EXP];
  assign wr       = psel & penable & pwrite & st.pready;
  assign setup    = psel & ~penable;

  always_comb begin
    next_st = st;

    // Two-stage synchronisers for pins and straps
    next_st.sync1   = pin_in;
    next_st.sync2   = st.sync1;
    next_st.mode_s1 = mode_pins;
    next_st.mode_s2 = st.mode_s1;

    // Strap captured once, after it has crossed both stages
    if (!st.mode_ok) begin
      next_st.strap_age = st.strap_age + 2'h1;
      if (st.strap_age == pio_pkg::STRAP_WAIT) begin
        next_st.mode    = st.mode_s2;
        next_st.mode_ok = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Register writes on the access edge
    // --------------------------------------------------------------
    if (wr && dec.hit) begin
      if (dec.data && dec.port != pio_pkg::PORT_E) begin
        next_st.latch[dec.port] = pwdata[7:0]
                                & pio_pkg::PIN_MASK[dec.port];
      end
      if (dec.dir) begin
        next_st.dir[dec.port] = pwdata[7:0]
                              & pio_pkg::PIN_MASK[dec.port];
      end
      if (dec.sysopt) begin
        next_st.od = pwdata[pio_pkg::OD_BIT];
        if (!st.irv_done) begin
          next_st.irv      = pwdata[pio_pkg::IRV_BIT];
          next_st.irv_done = 1'b1;
        end
      end
      if (dec.pull) begin
        next_st.pull      = pwdata[3:0];
        next_st.pull_gate = pwdata[pio_pkg::PGATE_BIT];
      end
      if (dec.csc) begin
        next_st.cs_en = pwdata[3:0];
        next_st.xa_en = pwdata[pio_pkg::XA_BIT];
      end
    end

    // --------------------------------------------------------------
    // Pin read-back
    // --------------------------------------------------------------
    rd_pins = st.sync2;
    if (sgl_mode && st.od) begin
      rd_pins[pio_pkg::PORT_C] = (st.dir[pio_pkg::PORT_C]
                                 & st.latch[pio_pkg::PORT_C])
                               | (~st.dir[pio_pkg::PORT_C]
                                 & st.sync2[pio_pkg::PORT_C]);
    end

    // --------------------------------------------------------------
    // Read data, answered in the access phase
    // --------------------------------------------------------------
    rd = 8'h00;
    if (dec.data) begin
      rd = rd_pins[dec.port] & pio_pkg::PIN_MASK[dec.port];
    end
    if (dec.dir) begin
      rd = st.dir[dec.port];
    end
    if (dec.sysopt) begin
      rd[pio_pkg::OD_BIT]  = st.od;
      rd[pio_pkg::IRV_BIT] = st.irv;
    end
    if (dec.pull) begin
      rd[3:0]                = st.pull;
      rd[pio_pkg::PGATE_BIT] = st.pull_gate;
    end
    if (dec.csc) begin
      rd[3:0]             = st.cs_en;
      rd[pio_pkg::XA_BIT] = st.xa_en;
    end
    next_st.pready  = setup;
    next_st.pslverr = setup & ~dec.hit;
    next_st.prdata  = (setup && !pwrite) ? {24'h000000, rd} : 32'h00000000;

    // --------------------------------------------------------------
    // Special pin functions
    // --------------------------------------------------------------
    sp_en  = '0;
    sp_oe  = '0;
    sp_out = '0;
    sp_en[pio_pkg::PORT_A]  = timer_func.en;
    sp_oe[pio_pkg::PORT_A]  = timer_func.oe;
    sp_out[pio_pkg::PORT_A] = timer_func.out;
    sp_en[pio_pkg::PORT_D]  = serial_func.en
                            & pio_pkg::PIN_MASK[pio_pkg::PORT_D];
    sp_oe[pio_pkg::PORT_D]  = serial_func.oe;
    sp_out[pio_pkg::PORT_D] = serial_func.out;
    if (exp_mode) begin
      sp_en[pio_pkg::PORT_B]  = 8'hFF;
      sp_oe[pio_pkg::PORT_B]  = 8'hFF;
      sp_out[pio_pkg::PORT_B] = ext.addr[15:8];
      sp_en[pio_pkg::PORT_F]  = 8'hFF;
      sp_oe[pio_pkg::PORT_F]  = 8'hFF;
      sp_out[pio_pkg::PORT_F] = ext.addr[7:0];
      sp_en[pio_pkg::PORT_C]  = 8'hFF;
      sp_oe[pio_pkg::PORT_C]  = {8{ext.write
                                   | (st.irv & ext.rvis)}};
      sp_out[pio_pkg::PORT_C] = ext.write ? ext.wdata
                                          : ext.rvis_data;
      sp_en[pio_pkg::PORT_G][7]  = 1'b1;
      sp_oe[pio_pkg::PORT_G][7]  = 1'b1;
      sp_out[pio_pkg::PORT_G][7] = ~ext.write;
      if (st.xa_en) begin
        sp_en[pio_pkg::PORT_G][5:0]  = 6'h3F;
        sp_oe[pio_pkg::PORT_G][5:0]  = 6'h3F;
        sp_out[pio_pkg::PORT_G][5:0] = ext.xaddr;
      end
      sp_en[pio_pkg::PORT_H][7:4]  = st.cs_en;
      sp_oe[pio_pkg::PORT_H][7:4]  = st.cs_en;
      sp_out[pio_pkg::PORT_H][7:4] = cs_sel;
    end
    sp_en[pio_pkg::PORT_H][3:0]  = pwm_en;
    sp_oe[pio_pkg::PORT_H][3:0]  = pwm_en;
    sp_out[pio_pkg::PORT_H][3:0] = pwm_out;

    // --------------------------------------------------------------
    // Pin drivers: function first, else direction and latch
    // --------------------------------------------------------------
    for (int p = 0; p < pio_pkg::NPORT; p++) begin
      next_st.poe[p]  = ((sp_en[p] & sp_oe[p]) | (~sp_en[p] & st.dir[p]))
                      & pio_pkg::PIN_MASK[p];
      next_st.pout[p] = ((sp_en[p] & sp_out[p])
                        | (~sp_en[p] & st.latch[p]))
                      & pio_pkg::PIN_MASK[p];
    end
    next_st.poe[pio_pkg::PORT_E]  = 8'h00;
    next_st.pout[pio_pkg::PORT_E] = 8'h00;
    if (sgl_mode && st.od) begin
      next_st.poe[pio_pkg::PORT_C]  = st.dir[pio_pkg::PORT_C]
                                    & ~st.latch[pio_pkg::PORT_C];
      next_st.pout[pio_pkg::PORT_C] = 8'h00;
    end

    // Bus clock, held low for single-chip read visibility
    next_st.e_tog = ~st.e_tog;
    next_st.e_clk = st.e_tog & ~(sgl_mode & st.irv);

    // Pullups: B and F are address outputs when expanded
    next_st.pull_en = {4{st.pull_gate}} & st.pull
                    & {2'b11, ~exp_mode, ~exp_mode};

    next_st.ext_rdata = st.sync2[pio_pkg::PORT_C];
    next_st.an_data   = analog_en ? st.sync2[pio_pkg::PORT_E]
                                  : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= pio_pkg::ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign pin_out     = st.pout;
  assign pin_oe      = st.poe;
  assign analog_data = st.an_data;
  assign ext_rdata   = st.ext_rdata;
  assign e_clk       = st.e_clk;
  assign pullup_en   = st.pull_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_irv_once: assert property (
    (st.irv_done && wr && dec.sysopt) |=> $stable(st.irv))
    else $error("read visibility changed after first write");

  chk_od_nohigh: assert property (
    (sgl_mode && st.od) |=>
      (st.poe[pio_pkg::PORT_C] & st.pout[pio_pkg::PORT_C]) == 8'h00)
    else $error("open-drain port C drove high");

  chk_e_held: assert property (
    (sgl_mode && st.irv) [*2] |-> !st.e_clk)
    else $error("bus clock not held low");

  chk_addr_high: assert property (
    exp_mode |=> st.poe[pio_pkg::PORT_B] == 8'hFF
      && st.pout[pio_pkg::PORT_B] == $past(ext.addr[15:8]))
    else $error("port B not on upper address");

  chk_addr_low: assert property (
    exp_mode |=> st.pout[pio_pkg::PORT_F] == $past(ext.addr[7:0]))
    else $error("port F not on lower address");

  chk_pe_input: assert property (
    st.poe[pio_pkg::PORT_E] == 8'h00)
    else $error("port E driven");

  chk_apb_ready: assert property (
    setup |=> pready ##1 !pready)
    else $error("access not answered in one cycle");

  chk_latch_write: assert property (
    (wr && dec.data && dec.port == pio_pkg::PORT_A) |=>
      st.latch[pio_pkg::PORT_A] == $past(pwdata[7:0]))
    else $error("port A latch missed write");

  chk_dir_gpio: assert property (
    (serial_func.en == 8'h00) |=>
      st.poe[pio_pkg::PORT_D][5:0] == $past(st.dir[pio_pkg::PORT_D][5:0]))
    else $error("port D enable does not follow direction");

  chk_rw_strobe: assert property (
    exp_mode |=> st.poe[pio_pkg::PORT_G][7]
      && st.pout[pio_pkg::PORT_G][7] == !$past(ext.write))
    else $error("read/write strobe wrong");

  chk_pwm_pins: assert property (
    (pwm_en != 4'h0) |=>
      (st.poe[pio_pkg::PORT_H][3:0] & $past(pwm_en)) == $past(pwm_en)
      && ((st.pout[pio_pkg::PORT_H][3:0] ^ $past(pwm_out))
          & $past(pwm_en)) == 4'h0)
    else $error("pulse-width pins not handed over");

  chk_dir_write: assert property (
    (wr && dec.dir && dec.port == pio_pkg::PORT_B) |=>
      st.dir[pio_pkg::PORT_B] == $past(pwdata[7:0]))
    else $error("port B direction missed write");

  chk_pull_addr: assert property (
    exp_mode |=> st.pull_en[1:0] == 2'b00)
    else $error("pullup enabled on address port");

  chk_rvis_drive: assert property (
    (exp_mode && st.irv && ext.rvis && !ext.write) |=>
      st.poe[pio_pkg::PORT_C] == 8'hFF
      && st.pout[pio_pkg::PORT_C] == $past(ext.rvis_data))
    else $error("internal read not driven on port C");

  chk_xaddr_out: assert property (
    (exp_mode && st.xa_en) |=>
      st.poe[pio_pkg::PORT_G][5:0] == 6'h3F
      && st.pout[pio_pkg::PORT_G][5:0] == $past(ext.xaddr))
    else $error("port G not on extended address");

  chk_err_resp: assert property (
    (setup && !dec.hit) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

endmodule : pio_parallel_ports

// file: tb/pio_pin_model.sv
// Purpose: Board model seen by the parallel port pins.
// Assumes: An undriven pin shows the level that the far side sets.
// Notes:   Port C carries an external pullup for wired-OR use.
`timescale 1ns/1ps

module pio_pin_model (
  input  wire pio_pkg::pio_bank_t pin_out,
  input  wire pio_pkg::pio_bank_t pin_oe,
  input  wire pio_pkg::pio_bank_t far_level,
  output pio_pkg::pio_bank_t      pin_in
);

  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_oe[p][b] === 1'b1)
          pin_in[p][b] = pin_out[p][b];
        else if (p == 2)
          pin_in[p][b] = 1'b1;
        else
          pin_in[p][b] = far_level[p][b];
      end
    end
  end

endmodule : pio_pin_model

// file: tb/pio_parallel_ports_bench.sv
// Purpose: Self-checking bench of the parallel port block.
// Assumes: Board model resolves pins; APB master per hand-over timing.
// Notes:   Random GPIO traffic from a fixed seed plus mode corner cases.
`timescale 1ns/1ps

module pio_parallel_ports_bench;

  logic                       pclk, presetn, psel, penable, pwrite;
  logic [pio_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic                       pready, pslverr, er, analog_en, e_clk, a;
  logic [1:0]                 mode_pins;
  pio_pkg::pio_bank_t         pin_in, pin_out, pin_oe, far, lat, dr;
  pio_pkg::pio_func_t         tf, sf;
  pio_pkg::pio_ext_t          ext;
  logic [7:0]                 analog_data, ext_rdata, d, nd, m;
  logic [3:0]                 pwm_en, pwm_out, cs_sel, pullup_en, pu, hi;
  logic [23:0]                e;
  int                         miscompares, checked, cyc;

  pio_parallel_ports u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_pins(mode_pins),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .timer_func(tf), .serial_func(sf), .analog_en(analog_en),
    .analog_data(analog_data), .pwm_en(pwm_en), .pwm_out(pwm_out),
    .cs_sel(cs_sel), .ext(ext), .ext_rdata(ext_rdata), .e_clk(e_clk),
    .pullup_en(pullup_en)
  );

  pio_pin_model u_pins (
    .pin_out(pin_out), .pin_oe(pin_oe), .far_level(far), .pin_in(pin_in)
  );

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks and expectations
  // ----------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(n, 0);
  endtask : apb

  task do_reset(input logic [1:0] md);
    presetn   <= 1'b0;
    mode_pins <= md;
    repeat (6) @(posedge pclk);
    chk(pin_oe, 64'h0);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : do_reset

  // Returns {function enable, expected enable, expected driver}
  function automatic logic [23:0] gpio_exp(input int p);
    logic [7:0] en, fo, fv, oe;
    en = 8'h00;
    fo = 8'h00;
    fv = 8'h00;
    if (p == 0) begin
      en = tf.en; fo = tf.oe; fv = tf.out;
    end
    if (p == 3) begin
      en = sf.en & 8'h3F; fo = sf.oe; fv = sf.out;
    end
    if (p == 7) begin
      en = {4'h0, pwm_en}; fo = 8'hFF; fv = {4'h0, pwm_out};
    end
    oe = ((en & fo) | (~en & dr[p])) & pio_pkg::PIN_MASK[p];
    return {en, oe, (en & fv) | (~en & lat[p])};
  endfunction : gpio_exp

  function automatic logic [7:0] lvl(input int p, input logic [7:0] oe,
                                     input logic [7:0] v);
    return (oe & v) | (~oe & (p == 2 ? 8'hFF : far[p]));
  endfunction : lvl

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; mode_pins = 2'b01; far = '0;
    tf = '0; sf = '0; analog_en = 1'b0; pwm_en = '0; pwm_out = '0;
    cs_sel = '0; ext = '0; miscompares = 0; checked = 0; cyc = 0;
    rd = $urandom(97893);
    do_reset(2'b01);
    for (int it = 0; it < 20; it++) begin
      for (int p = 0; p < 8; p++) begin
        lat[p] = 8'($urandom);
        dr[p]  = 8'($urandom);
      end
      far       <= {$urandom, $urandom};
      tf        <= 24'($urandom);
      sf        <= 24'($urandom);
      pwm_en    <= 4'($urandom);
      pwm_out   <= 4'($urandom);
      analog_en <= 1'($urandom);
      pu = 4'($urandom);
      for (int p = 0; p < 8; p++) begin
        if (p != 4) begin
          apb(1'b1, pio_pkg::DIR_IDX[p], dr[p]);
          apb(1'b1, pio_pkg::DATA_IDX[p], lat[p]);
        end
      end
      apb(1'b1, pio_pkg::DATA_IDX[4], 8'($urandom));
      apb(1'b1, pio_pkg::PULL_IDX, {4'h8, pu});
      repeat (4) @(posedge pclk);
      chk(pullup_en, pu);
      chk(analog_data, analog_en ? far[4] : 8'h00);
      for (int p = 0; p < 8; p++) begin
        apb(1'b0, pio_pkg::DATA_IDX[p], 8'h00);
        if (p == 4) begin
          chk(rd, far[4]);
        end else begin
          e = gpio_exp(p);
          m = pio_pkg::PIN_MASK[p] & ~e[23:16];
          chk(rd[7:0] & m, lvl(p, e[15:8], e[7:0]) & m);
          chk(pin_oe[p], e[15:8]);
          chk(pin_out[p] & e[15:8], e[7:0] & e[15:8]);
          if (p == 2) begin
            chk(ext_rdata, lvl(p, e[15:8], e[7:0]));
          end
          apb(1'b0, pio_pkg::DIR_IDX[p], 8'h00);
          m = pio_pkg::PIN_MASK[p];
          chk(rd[7:0] & m, dr[p] & m);
        end
      end
    end
    $display("Test gpio_random done");

    tf <= '0;
    sf <= '0;
    pwm_en <= '0;
    d = 8'($urandom);
    nd = ~d;
    @(posedge pclk);
    a = e_clk;
    @(posedge pclk);
    chk(e_clk ^ a, 1'b1);
    apb(1'b1, pio_pkg::SYSOPT_IDX, 8'h30);
    apb(1'b1, pio_pkg::DIR_IDX[2], 8'hFF);
    apb(1'b1, pio_pkg::DATA_IDX[2], d);
    repeat (3) @(posedge pclk);
    chk(pin_oe[2], nd);
    chk(pin_out[2] & pin_oe[2], 8'h00);
    apb(1'b0, pio_pkg::DATA_IDX[2], 8'h00);
    chk(rd, d);
    apb(1'b1, pio_pkg::SYSOPT_IDX, 8'h30);
    apb(1'b1, pio_pkg::SYSOPT_IDX, 8'h00);
    apb(1'b0, pio_pkg::SYSOPT_IDX, 8'h00);
    chk(rd[5:4], 2'b01);
    hi = '0;
    repeat (8) begin
      @(posedge pclk);
      hi = hi + e_clk;
    end
    chk(hi, 4'h0);
    apb(1'b0, 8'h3F, 8'h00);
    chk({er, rd}, {1'b1, 32'h0});
    $display("Test option_bits done");

    ext <= '{addr: 16'($urandom), xaddr: 6'($urandom), wdata: 8'($urandom),
             write: 1'b1, rvis: 1'b0, rvis_data: 8'($urandom)};
    cs_sel <= 4'($urandom);
    do_reset(2'b11);
    chk(pin_oe, 64'h8080FF0000FFFF00);
    chk({pin_out[1], pin_out[5]}, ext.addr);
    chk(pin_out[2], ext.wdata);
    chk({pin_out[6][7], pin_out[7][7]}, {~ext.write, cs_sel[3]});
    ext.write <= 1'b0;
    ext.rvis  <= 1'b1;
    apb(1'b1, pio_pkg::SYSOPT_IDX, 8'h10);
    apb(1'b1, pio_pkg::DIR_IDX[1], 8'h00);
    apb(1'b1, pio_pkg::CSC_IDX, 8'h17);
    apb(1'b1, pio_pkg::PULL_IDX, 8'h8F);
    repeat (3) @(posedge pclk);
    chk(pullup_en, 4'hC);
    chk(pin_oe[1], 8'hFF);
    chk({pin_oe[2], pin_out[2]}, {8'hFF, ext.rvis_data});
    chk({pin_oe[7], pin_oe[6]}, 16'h70BF);
    chk(pin_out[6][5:0], ext.xaddr);
    chk(pin_out[7][6:4], cs_sel[2:0]);
    $display("Test expanded_mode done");
    complete_run();
  end

endmodule : pio_parallel_ports_bench
